//--- core/sfc_pkg.sv
// Constants and register layout for the speed and fault settings bank
//
// Operation
// - Speed curve six at 9Eh, parity resets zero
// - Bits 30..23 hold second turn-off speed
// - Bits 22..15 hold second clamp speed
// - Fault group: registers at 90h and 92h
// - Fault settings one resets zero, parity bit 31
// - Bits 30..27 pick torque loop current reference
// - R fields readable, W writable, suffix resets
package sfc_pkg;

	// ------------------------------------------------------------
	// Register indices and byte addresses
	// ------------------------------------------------------------
	localparam logic [9:0]  FAULT_ONE_IDX   = 10'h090;
	localparam logic [9:0]  FAULT_TWO_IDX   = 10'h092;
	localparam logic [9:0]  SPEED_SIX_IDX   = 10'h09e;
	localparam logic [9:0]  STATUS_IDX      = 10'h0a0;
	localparam logic [11:0] FAULT_ONE_ADDR  = {FAULT_ONE_IDX, 2'b00};
	localparam logic [11:0] FAULT_TWO_ADDR  = {FAULT_TWO_IDX, 2'b00};
	localparam logic [11:0] SPEED_SIX_ADDR  = {SPEED_SIX_IDX, 2'b00};
	localparam logic [11:0] STATUS_ADDR     = {STATUS_IDX, 2'b00};

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int PARITY_BIT      = 31;
	localparam int TURNOFF_MSB     = 30;
	localparam int TURNOFF_LSB     = 23;
	localparam int CLAMP_MSB       = 22;
	localparam int CLAMP_LSB       = 15;
	localparam int ILIMIT_MSB      = 30;
	localparam int ILIMIT_LSB      = 27;
	localparam int STAT_WR_LSB     = 0;
	localparam int STAT_PAR_LSB    = 8;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [31:0] FAULT_ONE_RST  = 32'h0000_0000;
	localparam logic [31:0] FAULT_TWO_RST  = 32'h0000_0000;
	localparam logic [31:0] SPEED_SIX_RST  = 32'h0000_0000;

	// ------------------------------------------------------------
	// Bus encodings
	// ------------------------------------------------------------
	localparam logic [2:0]  HSIZE_WORD     = 3'h2;
	localparam int          TRANS_ACT_BIT  = 1;

	// ------------------------------------------------------------
	// Torque loop current reference, in milliamps per code
	// ------------------------------------------------------------
	localparam int ILIM_MA_W = 14;
	localparam logic [ILIM_MA_W-1:0] ILIM_MA_TABLE [16] = '{
		14'h007d, 14'h00fa, 14'h01f4, 14'h03e8,
		14'h05dc, 14'h07d0, 14'h09c4, 14'h0bb8,
		14'h0dac, 14'h0fa0, 14'h1194, 14'h1388,
		14'h157c, 14'h1770, 14'h1b58, 14'h1f40
	};

endpackage : sfc_pkg

//--- core/sfc_ilimit_decode.sv
// Torque loop current reference decoder, code to milliamps
`timescale 1ns/10ps
module sfc_ilimit_decode
(
	input  wire logic                        sys_clk_i,
	input  wire logic                        rst_b_i,
	input  wire logic [3:0]                  code_i,
	output logic      [sfc_pkg::ILIM_MA_W-1:0] ma_o
);

	// ------------------------------------------------------------
	// Lookup
	// ------------------------------------------------------------
	// Steps double below 1 A, then 0.5 A, then 1 A at the top
	wire logic [sfc_pkg::ILIM_MA_W-1:0] ma_next = sfc_pkg::ILIM_MA_TABLE[code_i];

	// ------------------------------------------------------------
	// Output register
	// ------------------------------------------------------------
	logic [sfc_pkg::ILIM_MA_W-1:0] ma_reg;

	always_ff @(posedge sys_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			ma_reg <= sfc_pkg::ILIM_MA_TABLE[0];
		else
			ma_reg <= ma_next;
	end

	assign ma_o = ma_reg;

endmodule : sfc_ilimit_decode

//--- core/sfc_regs.sv
// Speed curve and fault settings register bank behind an AHB-Lite slave
//
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/10ps
module sfc_regs
#(
	parameter int ADDR_W = 12
)
(
	input  wire logic              sys_clk_i,
	input  wire logic              rst_b_i,
	// AHB-Lite slave
	input  wire logic              hsel_i,
	input  wire logic [ADDR_W-1:0] haddr_i,
	input  wire logic [1:0]        htrans_i,
	input  wire logic              hwrite_i,
	input  wire logic [2:0]        hsize_i,
	input  wire logic [31:0]       hwdata_i,
	input  wire logic              hready_i,
	output logic      [31:0]       hrdata_o,
	output logic                   hreadyout_o,
	output logic                   hresp_o,
	// Settings toward the motor control logic
	output logic      [31:0]       speed_curve_six_o,
	output logic      [7:0]        second_turnoff_speed_o,
	output logic      [7:0]        second_clamp_speed_o,
	output logic      [31:0]       fault_settings_one_o,
	output logic      [31:0]       fault_settings_two_o,
	output logic      [3:0]        torque_ilimit_code_o,
	output logic      [13:0]       torque_ilimit_ma_o
);

	// ------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------
	// Decode compares the low twelve address bits; the highest byte address, 280h, fits in ten
	if (ADDR_W < 12)
	begin : g_addr_check
		$error("sfc_regs: ADDR_W must be at least 12");
	end

	// ------------------------------------------------------------
	// Address phase decode
	// ------------------------------------------------------------
	wire logic              addr_act;
	wire logic              size_word;
	wire logic [11:0]       addr_low;
	wire logic              hit_fault_one;
	wire logic              hit_fault_two;
	wire logic              hit_speed_six;
	wire logic              hit_status;
	wire logic              upper_zero;
	wire logic [3:0]        hit_vec;

	assign addr_act      = hsel_i & htrans_i[sfc_pkg::TRANS_ACT_BIT] & hready_i;
	assign size_word     = (hsize_i == sfc_pkg::HSIZE_WORD);
	assign addr_low      = haddr_i[11:0];

	if (ADDR_W > 12)
	begin : g_upper
		assign upper_zero = ~|haddr_i[ADDR_W-1:12];
	end
	else
	begin : g_no_upper
		assign upper_zero = 1'b1;
	end

	// Only the listed fault offsets decode; the rest stay reserved
	assign hit_fault_one = upper_zero
		& (addr_low == sfc_pkg::FAULT_ONE_ADDR);
	assign hit_fault_two = upper_zero
		& (addr_low == sfc_pkg::FAULT_TWO_ADDR);
	assign hit_speed_six = upper_zero
		& (addr_low == sfc_pkg::SPEED_SIX_ADDR);
	assign hit_status    = upper_zero
		& (addr_low == sfc_pkg::STATUS_ADDR);
	assign hit_vec       = {hit_status, hit_speed_six,
		hit_fault_two, hit_fault_one};

	// ------------------------------------------------------------
	// Data phase state
	// ------------------------------------------------------------
	// Writes land in the data phase because hwdata only arrives then
	logic              wr_pend_reg;
	logic              wr_pend_next;
	logic [2:0]        wr_sel_reg;
	logic [2:0]        wr_sel_next;

	// Byte and halfword writes are dropped; reads of any size return the whole word
	assign wr_pend_next = addr_act & hwrite_i & size_word;
	assign wr_sel_next  = hit_vec[2:0];

	always_ff @(posedge sys_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			wr_pend_reg <= 1'b0;
			wr_sel_reg  <= 3'h0;
		end
		else
		begin
			wr_pend_reg <= wr_pend_next;
			wr_sel_reg  <= wr_sel_next;
		end
	end

	// ------------------------------------------------------------
	// Register storage
	// ------------------------------------------------------------
	logic [31:0] bank_reg [3];
	wire  logic [2:0]  bank_we;

	// Constants only, so the asynchronous reset branch stays clean
	localparam logic [31:0] BANK_RST [3] = '{
		sfc_pkg::FAULT_ONE_RST,
		sfc_pkg::FAULT_TWO_RST,
		sfc_pkg::SPEED_SIX_RST
	};

	genvar gi;
	for (gi = 0; gi < 3; gi++)
	begin : g_bank
		assign bank_we[gi] = wr_pend_reg & wr_sel_reg[gi];

		// Parity bit is kept as written, no field reacts to it
		always_ff @(posedge sys_clk_i or negedge rst_b_i)
		begin
			if (!rst_b_i)
				bank_reg[gi] <= BANK_RST[gi];
			else if (bank_we[gi])
				bank_reg[gi] <= hwdata_i;
		end
	end

	// ------------------------------------------------------------
	// Status: written flags and odd parity of each register
	// ------------------------------------------------------------
	// Flags are only ever set, so no set and clear can collide
	logic [2:0]        written_reg;
	wire  logic [2:0]  written_next;
	wire  logic [2:0]  par_odd;

	assign written_next = written_reg | bank_we;

	for (gi = 0; gi < 3; gi++)
	begin : g_par
		// Parity follows the forwarded word, like the written flags
		assign par_odd[gi] = ^(bank_we[gi] ? hwdata_i : bank_reg[gi]);
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			written_reg <= 3'h0;
		else
			written_reg <= written_next;
	end


	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	// A write still in its data phase is forwarded, so a read right
	// behind it sees the new value rather than the stale one
	wire logic [31:0] view [3];
	wire logic [31:0] rd_mux;
	wire logic [31:0] wr_status;
	wire logic        rd_take;

	for (gi = 0; gi < 3; gi++)
	begin : g_view
		assign view[gi] = bank_we[gi] ? hwdata_i : bank_reg[gi];
	end

	assign wr_status = {21'h00_0000, par_odd, 5'h00, written_next};

	// Unmapped and reserved offsets read as zero
	assign rd_mux =
		({32{hit_fault_one}} & view[0])
		| ({32{hit_fault_two}} & view[1])
		| ({32{hit_speed_six}} & view[2])
		| ({32{hit_status}} & wr_status);

	assign rd_take = addr_act & ~hwrite_i;

	logic [31:0] hrdata_reg;
	logic [31:0] hrdata_next;

	assign hrdata_next = rd_take ? rd_mux : 32'h0000_0000;

	always_ff @(posedge sys_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			hrdata_reg <= 32'h0000_0000;
		else
			hrdata_reg <= hrdata_next;
	end

	// Zero wait state slave that always answers OKAY
	assign hrdata_o    = hrdata_reg;
	assign hreadyout_o = 1'b1;
	assign hresp_o     = 1'b0;

	// ------------------------------------------------------------
	// Settings outputs
	// ------------------------------------------------------------
	assign fault_settings_one_o   = bank_reg[0];
	assign fault_settings_two_o   = bank_reg[1];
	assign speed_curve_six_o      = bank_reg[2];

	// Value n means n/255 of the maximum speed
	assign second_turnoff_speed_o =
		bank_reg[2][sfc_pkg::TURNOFF_MSB:sfc_pkg::TURNOFF_LSB];
	assign second_clamp_speed_o   =
		bank_reg[2][sfc_pkg::CLAMP_MSB:sfc_pkg::CLAMP_LSB];
	assign torque_ilimit_code_o   =
		bank_reg[0][sfc_pkg::ILIMIT_MSB:sfc_pkg::ILIMIT_LSB];

	// ------------------------------------------------------------
	// Current reference decoder
	// ------------------------------------------------------------
	// One cycle behind the code, which settles long before use
	sfc_ilimit_decode u_ilimit
	(
		.sys_clk_i (sys_clk_i),
		.rst_b_i   (rst_b_i),
		.code_i    (torque_ilimit_code_o),
		.ma_o      (torque_ilimit_ma_o)
	);

endmodule : sfc_regs

//--- tb/sfc_checker.sv
// Concurrent checks on the settings bank ports
`timescale 1ns/10ps
module sfc_checker
#(
	parameter int ADDR_W = 12
)
(
	input wire logic              sys_clk_i,
	input wire logic              rst_b_i,
	input wire logic              hsel_i,
	input wire logic [ADDR_W-1:0] haddr_i,
	input wire logic [1:0]        htrans_i,
	input wire logic              hwrite_i,
	input wire logic [2:0]        hsize_i,
	input wire logic [31:0]       hwdata_i,
	input wire logic              hready_i,
	input wire logic [31:0]       hrdata_o,
	input wire logic              hreadyout_o,
	input wire logic              hresp_o,
	input wire logic [31:0]       speed_curve_six_o,
	input wire logic [7:0]        second_turnoff_speed_o,
	input wire logic [7:0]        second_clamp_speed_o,
	input wire logic [31:0]       fault_settings_one_o,
	input wire logic [31:0]       fault_settings_two_o,
	input wire logic [3:0]        torque_ilimit_code_o,
	input wire logic [13:0]       torque_ilimit_ma_o
);
// ------------------------------------------------------------
// Checks
// ------------------------------------------------------------
wire act = hsel_i && htrans_i[1] && hready_i;
wire mapped = haddr_i inside {12'h240, 12'h248, 12'h278, 12'h280};
function automatic logic [13:0] ma_of(logic [3:0] c);
	return c < 4'h3 ? 14'h007d << c : c == 4'he ? 14'h1b58 :
		c == 4'hf ? 14'h1f40 : 14'(int'(c) * 500 - 500);
endfunction : ma_of
sequence wr_s(logic [ADDR_W-1:0] a);
	act && hwrite_i && hsize_i == sfc_pkg::HSIZE_WORD && haddr_i == a;
endsequence
default clocking cb @(posedge sys_clk_i);
endclocking
default disable iff (!rst_b_i);
bus_okay_a: assert property (hreadyout_o && !hresp_o)
	else $error("bus not ready or not okay");
turnoff_field_a: assert property (
	second_turnoff_speed_o == speed_curve_six_o[30:23]) else $error("turnoff");
clamp_field_a: assert property (
	second_clamp_speed_o == speed_curve_six_o[22:15]) else $error("clamp");
ilim_code_a: assert property (
	torque_ilimit_code_o == fault_settings_one_o[30:27]) else $error("code");
ilim_ma_a: assert property (1'b1 |=>
	torque_ilimit_ma_o == ma_of($past(torque_ilimit_code_o)))
	else $error("current reference wrong");
write_one_a: assert property (wr_s(12'h240) |=> ##1
	fault_settings_one_o == $past(hwdata_i)) else $error("one not written");
write_two_a: assert property (wr_s(12'h248) |=> ##1
	fault_settings_two_o == $past(hwdata_i)) else $error("two not written");
write_six_a: assert property (wr_s(12'h278) |=> ##1
	speed_curve_six_o == $past(hwdata_i)) else $error("six not written");
odd_write_a: assert property (
	act && hwrite_i && hsize_i != 3'h2 |=> ##1
	$stable(fault_settings_one_o) && $stable(fault_settings_two_o)
	&& $stable(speed_curve_six_o)) else $error("non-word write took");
hole_read_a: assert property (act && !hwrite_i && !mapped |=>
	hrdata_o == 32'h0000_0000) else $error("reserved read not zero");
read_one_a: assert property (
	act && !hwrite_i && haddr_i == 12'h240 |=>
	hrdata_o == fault_settings_one_o) else $error("read one wrong");
reset_val_a: assert property ($rose(rst_b_i) |->
	fault_settings_one_o == 32'h0000_0000 && torque_ilimit_ma_o == 14'h007d)
	else $error("reset values wrong");
endmodule : sfc_checker
bind sfc_regs sfc_checker #(.ADDR_W(ADDR_W)) u_chk (.sys_clk_i(sys_clk_i),
	.rst_b_i(rst_b_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
	.htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
	.hwdata_i(hwdata_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
	.hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
	.speed_curve_six_o(speed_curve_six_o),
	.second_turnoff_speed_o(second_turnoff_speed_o),
	.second_clamp_speed_o(second_clamp_speed_o),
	.fault_settings_one_o(fault_settings_one_o),
	.fault_settings_two_o(fault_settings_two_o),
	.torque_ilimit_code_o(torque_ilimit_code_o),
	.torque_ilimit_ma_o(torque_ilimit_ma_o));

//--- tb/tb_speed_fault_config_regs.sv
// Self-checking bench for the settings bank
`timescale 1ns/10ps
module tb_speed_fault_config_regs;
// ------------------------------------------------------------
// Bench
// ------------------------------------------------------------
logic sys_clk_i = 0, rst_b_i = 0, hsel_i = 0, hwrite_i = 0;
logic [11:0] haddr_i = 12'h000;
logic [1:0] htrans_i = 2'h0;
logic [2:0] hsize_i = 3'h2;
logic [31:0] hwdata_i = 32'h0, hrdata_o, six, one, two;
logic hreadyout_o, hresp_o;
logic [7:0] toff, clmp;
logic [3:0] code;
logic [13:0] ma;
int n_errors = 0, samples_checked = 0;
sfc_regs #(.ADDR_W(12)) DUT (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
	.hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
	.hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
	.hready_i(hreadyout_o), .hrdata_o(hrdata_o),
	.hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
	.speed_curve_six_o(six), .second_turnoff_speed_o(toff),
	.second_clamp_speed_o(clmp), .fault_settings_one_o(one),
	.fault_settings_two_o(two), .torque_ilimit_code_o(code),
	.torque_ilimit_ma_o(ma));
initial
begin
	forever #5 sys_clk_i = ~sys_clk_i;
end
task automatic chk(input logic [31:0] got, input logic [31:0] exp);
	samples_checked++;
	if (got !== exp)
	begin
		n_errors++;
		$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
	end
endtask : chk
// Waits on ready; no fixed latency is assumed
task automatic bus(input logic w, input logic [11:0] a,
	input logic [31:0] d, input logic [2:0] sz, output logic [31:0] r);
	@(posedge sys_clk_i);
	hsel_i <= 1'b1;
	haddr_i <= a;
	htrans_i <= 2'h2;
	hwrite_i <= w;
	hsize_i <= sz;
	do @(posedge sys_clk_i); while (hreadyout_o !== 1'b1);
	hsel_i <= 1'b0;
	htrans_i <= 2'h0;
	hwdata_i <= d;
	do @(posedge sys_clk_i); while (hreadyout_o !== 1'b1);
	r = hrdata_o;
endtask : bus
task automatic wr(input logic [11:0] a, input logic [31:0] d);
	logic [31:0] r;
	bus(1'b1, a, d, 3'h2, r);
endtask : wr
task automatic rd(input logic [11:0] a, input logic [31:0] exp);
	logic [31:0] r;
	bus(1'b0, a, 32'h0, 3'h2, r);
	chk(r, exp);
endtask : rd
function automatic logic [13:0] exp_ma(int c);
	return c < 3 ? 14'(125 << c) : c == 14 ? 14'h1b58 :
		c == 15 ? 14'h1f40 : 14'(500 * c - 500);
endfunction : exp_ma
task automatic t_reset;
	chk({18'h0, ma}, 32'h007d);
	rd(12'h240, 32'h0000_0000);
	rd(12'h278, 32'h0000_0000);
endtask : t_reset
task automatic t_speed;
	wr(12'h278, {1'b1, 8'ha5, 8'h3c, 15'h1234});
	rd(12'h278, {1'b1, 8'ha5, 8'h3c, 15'h1234});
	chk({24'h0, toff}, 32'h00a5);
	chk({24'h0, clmp}, 32'h003c);
endtask : t_speed
task automatic t_ilimit;
	logic [3:0] c;
	for (int i = 0; i < 16; i++)
	begin
		c = 4'(i);
		wr(12'h240, {c[0], c, 27'h5a5_a5a5});
		repeat (2) @(posedge sys_clk_i);
		chk({28'h0, code}, {28'h0, c});
		chk({18'h0, ma}, {18'h0, exp_ma(i)});
	end
endtask : t_ilimit
// Holes and short writes must leave every register as it was
task automatic t_group;
	logic [31:0] r;
	wr(12'h248, 32'hdead_beef);
	rd(12'h248, 32'hdead_beef);
	// Reserved holes are only read, never written
	bus(1'b1, 12'h240, 32'h0000_0001, 3'h1, r);
	rd(12'h244, 32'h0000_0000);
	rd(12'h240, {1'b1, 4'hf, 27'h5a5_a5a5});
	rd(12'h248, 32'hdead_beef);
	// All three written; odd parity only in fault settings one
	rd(12'h280, 32'h0000_0107);
endtask : t_group
task automatic test_done;
	$display("errors %0d checks %0d", n_errors, samples_checked);
	if (n_errors == 0 && samples_checked > 0)
		$display("bench passed");
	else
		$display("bench failed");
	$finish;
endtask : test_done
initial
begin
	#100000;
	n_errors++;
	test_done();
end
initial
begin
	repeat (6) @(posedge sys_clk_i);
	rst_b_i <= 1'b1;
	@(posedge sys_clk_i);
	t_reset();
	t_speed();
	t_ilimit();
	t_group();
	test_done();
end
endmodule : tb_speed_fault_config_regs
